// >>> logic/dac_ctrl_pkg.sv
`default_nettype none
package dac_ctrl_pkg;
   // Register map, byte addresses
   localparam logic [7:0] CTRL_OFS = 8'h00;
   localparam logic [7:0] SWT_OFS = 8'h04;
   localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
   localparam logic [31:0] SWT_RESET = 32'h0000_0000;
   // Writable bits of the control register, reserved bits stay zero
   localparam logic [31:0] CTRL_WMASK = 32'h1fff_1fff;
   localparam logic [31:0] SWT_WMASK = 32'h0000_0003;
   // Per-channel field layout, channel one sits one stride higher
   localparam int CH_STRIDE = 16;
   localparam int ON_BIT = 0;
   localparam int BUF_OFF_BIT = 1;
   localparam int TRIG_ON_BIT = 2;
   localparam int SRC_LSB = 3;
   localparam int MODE_LSB = 6;
   localparam int WIDTH_LSB = 8;
   localparam int DMA_BIT = 12;
   // Trigger source codes
   localparam logic [2:0] SRC_EXT_LINE = 3'h6;
   localparam logic [2:0] SRC_SOFT = 3'h7;
   localparam int TIMER_SRC_N = 6;
   // Wave modes
   localparam logic [1:0] WAVE_OFF = 2'h0;
   localparam logic [1:0] WAVE_NOISE = 2'h1;
   localparam logic [3:0] WIDTH_MAX_CODE = 4'hb;
   // Noise register start value and feedback taps
   localparam logic [11:0] LFSR_SEED = 12'haaa;
   localparam logic [11:0] LFSR_TAPS = 12'h829;
endpackage
`default_nettype wire

// >>> logic/chan_if.sv
`timescale 1ns/1ps
`default_nettype none
interface chan_if #(parameter int DATA_W = 12);
   logic on;
   logic trigOn;
   logic [1:0] waveMode;
   logic [3:0] waveWidth;
   logic fire;
   logic [DATA_W-1:0] holdData;
   logic [DATA_W-1:0] outData;
   modport ctrl (output on, trigOn, waveMode, waveWidth, fire, holdData, input outData);
   modport chan (input on, trigOn, waveMode, waveWidth, fire, holdData, output outData);
endinterface
`default_nettype wire

// >>> logic/dac_wave_channel.sv
`timescale 1ns/1ps
`default_nettype none
module dac_wave_channel
   import dac_ctrl_pkg::*;
#(
   parameter int DATA_W = 12
) (
   input wire logic clk,
   input wire logic rstn,
   chan_if.chan bus
);
   logic [DATA_W-1:0] lfsr_r;
   logic [DATA_W-1:0] tri_r;
   logic triUp_r;
   logic [DATA_W-1:0] outData_r;
   logic [DATA_W-1:0] amp;
   logic [DATA_W-1:0] wave;
   logic [DATA_W:0] sum;
   logic update;

   // All-ones mask of n bits, n = code + 1 capped at 12
   function automatic logic [DATA_W-1:0] widthMask(input logic [3:0] code);
      logic [3:0] idx;
      idx = (code >= WIDTH_MAX_CODE) ? WIDTH_MAX_CODE : code;
      return {DATA_W{1'b1}} >> (WIDTH_MAX_CODE - idx);
   endfunction

   assign amp = widthMask(bus.waveWidth);
   // Trigger enabled: copy on the event; disabled: copy every cycle
   assign update = bus.trigOn ? bus.fire : 1'b1;

   always_comb begin
      if (!bus.trigOn || bus.waveMode == WAVE_OFF) begin
         wave = '0;
      end else if (bus.waveMode == WAVE_NOISE) begin
         wave = lfsr_r & amp;
      end else begin
         wave = tri_r;
      end
   end

   assign sum = {1'b0, bus.holdData} + {1'b0, wave};

   // Noise register advances on each taken trigger in noise mode
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         lfsr_r <= LFSR_SEED;
      end else if (!bus.on) begin
         lfsr_r <= LFSR_SEED;
      end else if (bus.fire && bus.waveMode == WAVE_NOISE) begin
         lfsr_r <= {lfsr_r[DATA_W-2:0], ^(lfsr_r & LFSR_TAPS)};
      end
   end

   // Triangle counter between 0 and the amplitude
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         tri_r <= '0;
         triUp_r <= 1'b1;
      end else if (!bus.on) begin
         tri_r <= '0;
         triUp_r <= 1'b1;
      end else if (bus.fire && bus.waveMode[1]) begin
         if (triUp_r) begin
            if (tri_r >= amp) begin
               triUp_r <= 1'b0;
               tri_r <= tri_r - 1'b1;
            end else begin
               tri_r <= tri_r + 1'b1;
            end
         end else begin
            if (tri_r == '0) begin
               triUp_r <= 1'b1;
               tri_r <= tri_r + 1'b1;
            end else begin
               tri_r <= tri_r - 1'b1;
            end
         end
      end
   end

   // Output data, sum saturates at full scale
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         outData_r <= '0;
      end else if (!bus.on) begin
         outData_r <= '0;
      end else if (update) begin
         outData_r <= sum[DATA_W] ? {DATA_W{1'b1}} : sum[DATA_W-1:0];
      end
   end

   assign bus.outData = outData_r;
endmodule
`default_nettype wire

// >>> logic/dac_channel_control_regs.sv
// Contract
// - Control at 0x00, resets zero, word access.
// - Bits 0/16 switch each channel on.
// - Bits 1/17 turn output buffer off.
// - Bits 2/18 enable the channel trigger.
// - Source field used only when trigger enabled.
// - Codes 0-5 timers, 6 line nine, 7 software.
// - Mode 00 off, 01 noise, 1x triangle.
// - Wave mode acts only with trigger enabled.
// - Width code k gives k+1, capped at 12.
// - Noise keeps only low n noise bits.
// - Triangle amplitude is (2<<(n-1))-1.
// - Bits 12/28 enable DMA per channel.
// - Soft trigger at 0x04, bits 0 and 1.
// - Writing one requests trigger, hardware clears it.
// - Copy on trigger event, else copy automatically.
// - Hardware triggers taken on rising edge.
// - DMA request on hardware triggers only.
// - Wave added to holding data for output.
//
// Decided for this implementation: strobed register access.
`timescale 1ns/1ps
`default_nettype none
module dac_channel_control_regs
   import dac_ctrl_pkg::*;
#(
   parameter int ADDR_W = 8,
   parameter int DATA_W = 12
) (
   input wire logic clk,
   input wire logic rstn,
   input wire logic [ADDR_W-1:0] regAddr,
   input wire logic [31:0] regWrData,
   input wire logic regWr,
   input wire logic regRd,
   output logic [31:0] regRdData,
   input wire logic [TIMER_SRC_N-1:0] timerTriggerOutput,
   input wire logic externalInterruptLine,
   input wire logic [DATA_W-1:0] holdingData0,
   input wire logic [DATA_W-1:0] holdingData1,
   output logic [DATA_W-1:0] converterChannelZero,
   output logic [DATA_W-1:0] converterChannelOne,
   output logic [1:0] chanOn,
   output logic [1:0] chanBufferOff,
   output logic [1:0] dmaReq
);
   localparam int TRIG_N = TIMER_SRC_N + 1;

   logic [31:0] ctrl_r;
   logic [1:0] softTrig_r;
   logic [31:0] rdData_r;
   logic [1:0] dmaReq_r;
   logic [TRIG_N-1:0] syncA_r;
   logic [TRIG_N-1:0] syncB_r;
   logic [TRIG_N-1:0] syncC_r;
   logic [TRIG_N-1:0] trigEdge;
   logic [1:0] hwFire;
   logic [1:0] swFire;
   logic ctrlSel;
   logic swtSel;

   chan_if #(.DATA_W(DATA_W)) chanBus[2] ();

   // Hardware event on the selected source, none for the software code
   function automatic logic pickHw(input logic [2:0] src, input logic [TRIG_N-1:0] edges);
      logic hit;
      hit = 1'b0;
      for (int i = 0; i < TRIG_N; i++) begin
         if (src == 3'(i)) begin
            hit = edges[i];
         end
      end
      return hit;
   endfunction

   assign ctrlSel = (regAddr == ADDR_W'(CTRL_OFS));
   assign swtSel = (regAddr == ADDR_W'(SWT_OFS));

   // Control register, reserved bits held at zero
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         ctrl_r <= CTRL_RESET;
      end else if (regWr && ctrlSel) begin
         ctrl_r <= regWrData & CTRL_WMASK;
      end
   end

   // Software trigger bits: set by a written one, set beats clear
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         softTrig_r <= SWT_RESET[1:0];
      end else begin
         for (int c = 0; c < 2; c++) begin
            if (regWr && swtSel && regWrData[c]) begin
               softTrig_r[c] <= 1'b1;
            end else if (softTrig_r[c]) begin
               softTrig_r[c] <= 1'b0;
            end
         end
      end
   end

   // Read data stand for one cycle only
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         rdData_r <= '0;
      end else if (regRd && ctrlSel) begin
         rdData_r <= ctrl_r;
      end else if (regRd && swtSel) begin
         rdData_r <= {30'h0, softTrig_r};
      end else begin
         rdData_r <= '0;
      end
   end

   // Trigger inputs through two flops, edge on the settled pair
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         syncA_r <= '0;
         syncB_r <= '0;
         syncC_r <= '0;
      end else begin
         syncA_r <= {externalInterruptLine, timerTriggerOutput};
         syncB_r <= syncA_r;
         syncC_r <= syncB_r;
      end
   end

   assign trigEdge = syncB_r & ~syncC_r;

   for (genvar ch = 0; ch < 2; ch++) begin : g_chan
      localparam int B = CH_STRIDE * ch;
      logic trigOn;
      logic [2:0] src;

      assign trigOn = ctrl_r[B + TRIG_ON_BIT];
      assign src = ctrl_r[B + SRC_LSB +: 3];
      assign hwFire[ch] = trigOn && pickHw(src, trigEdge);
      assign swFire[ch] = trigOn && src == SRC_SOFT && softTrig_r[ch];

      assign chanBus[ch].on = ctrl_r[B + ON_BIT];
      assign chanBus[ch].trigOn = trigOn;
      assign chanBus[ch].waveMode = ctrl_r[B + MODE_LSB +: 2];
      assign chanBus[ch].waveWidth = ctrl_r[B + WIDTH_LSB +: 4];
      assign chanBus[ch].fire = hwFire[ch] || swFire[ch];
      assign chanBus[ch].holdData = (ch == 0) ? holdingData0 : holdingData1;

      assign chanOn[ch] = ctrl_r[B + ON_BIT];
      assign chanBufferOff[ch] = ctrl_r[B + BUF_OFF_BIT];

      dac_wave_channel #(.DATA_W(DATA_W)) u_chan (
         .clk(clk),
         .rstn(rstn),
         .bus(chanBus[ch])
      );
   end

   // One-cycle DMA pulse per hardware trigger
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         dmaReq_r <= '0;
      end else begin
         for (int c = 0; c < 2; c++) begin
            dmaReq_r[c] <= hwFire[c] && ctrl_r[CH_STRIDE * c + DMA_BIT];
         end
      end
   end

   assign regRdData = rdData_r;
   assign dmaReq = dmaReq_r;
   assign converterChannelZero = chanBus[0].outData;
   assign converterChannelOne = chanBus[1].outData;
endmodule
`default_nettype wire

// >>> test/dac_ctrl_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module dac_ctrl_assertions
   import dac_ctrl_pkg::*;
#(parameter int ADDR_W = 8, parameter int DATA_W = 12) (
   input wire logic clk,
   input wire logic rstn,
   input wire logic [ADDR_W-1:0] regAddr,
   input wire logic [31:0] regWrData,
   input wire logic regWr,
   input wire logic regRd,
   input wire logic [31:0] regRdData,
   input wire logic [TIMER_SRC_N-1:0] timerTriggerOutput,
   input wire logic externalInterruptLine,
   input wire logic [DATA_W-1:0] converterChannelZero,
   input wire logic [1:0] chanOn,
   input wire logic [1:0] chanBufferOff,
   input wire logic [1:0] dmaReq
);
   wire logic anyHw = |timerTriggerOutput | externalInterruptLine;
   wire logic isCtl = regAddr == ADDR_W'(CTRL_OFS);
   wire logic isSwt = regAddr == ADDR_W'(SWT_OFS);
   default clocking @(posedge clk); endclocking
   default disable iff (!rstn);
   a_rd_idle_zero: assert property (!$past(regRd) |-> regRdData == 32'h0)
      else $error("read data not zero while idle");
   a_chan_on_map: assert property (regWr && isCtl |=>
      chanOn == {$past(regWrData[16]), $past(regWrData[0])}) else $error("chanOn mismatch");
   a_buf_off_map: assert property (regWr && isCtl |=>
      chanBufferOff == {$past(regWrData[17]), $past(regWrData[1])}) else $error("buffer off");
   a_unmapped_rd: assert property (regRd && !isCtl && !isSwt |=> regRdData == 32'h0)
      else $error("unmapped read not zero");
   a_swt_rsvd_zero: assert property (regRd && isSwt |=> regRdData[31:2] == 30'h0)
      else $error("trigger reserved bits set");
   a_ctl_rsvd_zero: assert property (regRd && isCtl |=> (regRdData & ~CTRL_WMASK) == 0)
      else $error("control reserved bits set");
   a_dma_one_pulse: assert property (dmaReq[0] |=> !dmaReq[0])
      else $error("dma request too long");
   a_dma1_one_pulse: assert property (dmaReq[1] |=> !dmaReq[1])
      else $error("channel one dma request too long");
   a_dma_from_hw: assert property (|dmaReq |-> $past(anyHw, 3))
      else $error("dma request without hardware edge");
   a_off_zero: assert property (!chanOn[0] && !$past(chanOn[0]) |->
      converterChannelZero == '0) else $error("channel off but output set");
endmodule
`default_nettype wire

// >>> test/trig_source_model.sv
`timescale 1ns/1ps
`default_nettype none
module trig_source_model (
   input wire logic clk,
   input wire logic [6:0] fire,
   output logic [5:0] timerTrig,
   output logic extLine
);
   logic [6:0] hi1_r;
   logic [6:0] hi2_r;
   always_ff @(posedge clk) begin
      hi1_r <= fire;
      hi2_r <= hi1_r;
   end
   // High two cycles, low otherwise
   assign {extLine, timerTrig} = hi1_r | hi2_r;
endmodule
`default_nettype wire

// >>> test/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top
   import dac_ctrl_pkg::*;
();
   logic clk = 1'b0, rstn = 1'b0, regWr = 1'b0, regRd = 1'b0, ext;
   logic [7:0] regAddr = 8'h0;
   logic [31:0] regWrData = 32'h0, rdData, rdv, v;
   logic [11:0] hold0 = 12'h0, hold1 = 12'h0, out0, out1, e0, e1;
   logic [6:0] fire = 7'h0;
   logic [5:0] tmr;
   logic [1:0] on, bufOff, dma;
   int errors = 0, cmpCount = 0, dmaCnt = 0, n;
   always #5 clk = ~clk;
   always @(posedge clk) if (dma !== 2'b00) dmaCnt++;
   dac_channel_control_regs u_dut (.clk(clk), .rstn(rstn), .regAddr(regAddr),
      .regWrData(regWrData), .regWr(regWr), .regRd(regRd), .regRdData(rdData),
      .timerTriggerOutput(tmr), .externalInterruptLine(ext), .holdingData0(hold0),
      .holdingData1(hold1), .converterChannelZero(out0), .converterChannelOne(out1),
      .chanOn(on), .chanBufferOff(bufOff), .dmaReq(dma));
   trig_source_model u_src (.clk(clk), .fire(fire), .timerTrig(tmr), .extLine(ext));
   task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
      cmpCount++;
      if (s !== e) begin
         errors++;
         $display("CHECK FAILED %s exp %h got %h", nm, e, s);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      regWr <= 1'b1; regAddr <= a; regWrData <= d;
      @(posedge clk);
      regWr <= 1'b0;
      #1;
   endtask
   task automatic rd(input logic [7:0] a, output logic [31:0] d);
      @(posedge clk);
      regRd <= 1'b1; regAddr <= a;
      @(posedge clk);
      regRd <= 1'b0;
      #1 d = rdData;
   endtask
   task automatic wait_cyc(input int k);
      repeat (k) @(posedge clk);
      #1;
   endtask
   task automatic hw_trig(input int i);
      @(posedge clk) fire <= 7'(1 << i);
      @(posedge clk) fire <= 7'h0;
      for (int k = 0; k < 8 && dma === 2'b00; k++) wait_cyc(1);
   endtask
   function automatic logic [31:0] cfg(input logic [2:0] s, input logic [1:0] m,
      input logic [3:0] w, input logic d, input logic t);
      return 32'(1) << ON_BIT | 32'(t) << TRIG_ON_BIT | 32'(s) << SRC_LSB
         | 32'(m) << MODE_LSB | 32'(w) << WIDTH_LSB | 32'(d) << DMA_BIT;
   endfunction
   function automatic logic [11:0] tri_val(input int i, input int w);
      int m;
      int r;
      m = (1 << w) - 1;
      r = i % (2 * m);
      return 12'(r <= m ? r : 2 * m - r);
   endfunction
   task automatic tally_and_finish;
      $display("comparisons %0d mismatches %0d", cmpCount, errors);
      if (errors == 0 && cmpCount > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   initial begin
      #50000;
      errors++;
      tally_and_finish;
   end
   initial begin
      void'($urandom(32'h0414));
      repeat (10) @(posedge clk);
      rstn <= 1'b1;
      rd(CTRL_OFS, rdv); chk("ctrl rst", rdv, CTRL_RESET);
      rd(SWT_OFS, rdv); chk("swt rst", rdv, SWT_RESET);
      chk("outs rst", {out0, out1, on, bufOff, dma}, 32'h0);
      repeat (8) begin
         v = $urandom & CTRL_WMASK;
         wr(CTRL_OFS, v);
         chk("on", on, {v[16], v[0]});
         chk("bufoff", bufOff, {v[17], v[1]});
         rd(CTRL_OFS, rdv); chk("ctrl rd", rdv, v);
      end
      rd(8'h08, rdv); chk("unmapped", rdv, 32'h0);
      $display("registers done");
      @(posedge clk);
      hold0 <= 12'($urandom);
      hold1 <= 12'($urandom);
      wr(CTRL_OFS, cfg(0, WAVE_NOISE, 4'hb, 0, 0) | cfg(0, 2'h2, 4'h3, 0, 0) << CH_STRIDE);
      wait_cyc(3);
      chk("auto copy", {out1, out0}, {hold1, hold0});
      for (int s = 0; s < 7; s++) begin
         wr(CTRL_OFS, cfg(3'(s), 0, 0, 1, 1) | cfg(3'(s), 0, 0, s[0], 1) << CH_STRIDE);
         e0 = hold0;
         e1 = hold1;
         @(posedge clk);
         hold0 <= 12'($urandom);
         hold1 <= 12'($urandom);
         wait_cyc(3);
         chk("held", {out1, out0}, {e1, e0});
         hw_trig(s);
         chk("dma", dma, {s[0], 1'b1});
         chk("copy", {out1, out0}, {hold1, hold0});
      end
      $display("hardware triggers done");
      wr(CTRL_OFS, cfg(7, 0, 0, 1, 1) | cfg(7, 0, 0, 1, 1) << CH_STRIDE);
      @(posedge clk);
      hold0 <= 12'($urandom);
      hold1 <= 12'($urandom);
      n = dmaCnt;
      wr(SWT_OFS, 32'h3);
      wait_cyc(2);
      chk("soft copy", {out1, out0}, {hold1, hold0});
      chk("soft no dma", dmaCnt, n);
      rd(SWT_OFS, rdv); chk("swt clear", rdv, 32'h0);
      $display("software trigger done");
      @(posedge clk);
      hold0 <= 12'h100;
      for (int c = 3; c < 16; c += 12) begin
         wr(CTRL_OFS, 32'h0);
         wr(CTRL_OFS, cfg(7, WAVE_NOISE, 4'(c), 0, 1));
         wr(SWT_OFS, 32'h1);
         wait_cyc(2);
         v = 32'(LFSR_SEED & 12'((1 << (c > 10 ? 12 : c + 1)) - 1));
         chk("noise", out0, 32'h100 + v);
      end
      for (int m = 2; m < 4; m++) begin
         wr(CTRL_OFS, 32'h0);
         wr(CTRL_OFS, cfg(7, 2'(m), 4'h1, 0, 1));
         for (int i = 0; i < 6; i++) begin
            wr(SWT_OFS, 32'h1);
            wait_cyc(2);
            chk("triangle", out0, 32'h100 + tri_val(i, 2));
         end
      end
      $display("waves done");
      tally_and_finish;
   end
endmodule
bind dac_channel_control_regs dac_ctrl_assertions #(.ADDR_W(ADDR_W), .DATA_W(DATA_W)) u_chk (
   .clk(clk), .rstn(rstn), .regAddr(regAddr), .regWrData(regWrData), .regWr(regWr),
   .regRd(regRd), .regRdData(regRdData), .timerTriggerOutput(timerTriggerOutput),
   .externalInterruptLine(externalInterruptLine), .converterChannelZero(converterChannelZero),
   .chanOn(chanOn), .chanBufferOff(chanBufferOff), .dmaReq(dmaReq));
`default_nettype wire
